// ### src/otpp_pkg.sv
// otpp_pkg: constants shared by the one-time programmable program/verify port.
// assumes a 50 MHz system clock and a 32-bit classic wishbone register bus.
package otpp_pkg;
  // store geometry
  localparam int          WORDS       = 2048;
  localparam int          WORD_W      = 16;
  localparam int          ADDR_W      = 11;
  localparam int          BYTE_W      = 8;
  localparam int          PULSES_STEP = 4;
  // timing: least reset hold before entry, rounded up to whole cycles
  localparam int          CLK_MHZ     = 50;
  localparam int          RST_HOLD_US = 10;
  localparam int          RST_HOLD_CY = RST_HOLD_US * CLK_MHZ;
  // mode select codes, bit 0 is pin 0
  localparam logic [3:0]  MODE_CLEAR  = 4'h5;
  localparam logic [3:0]  MODE_WRITE  = 4'he;
  localparam logic [3:0]  MODE_VERIFY = 4'hc;
  localparam logic [3:0]  INH_MASK    = 4'hd;
  localparam logic [3:0]  INH_CODE    = 4'hd;
  // register byte offsets
  localparam logic [3:0]  OFS_CTRL    = 4'h0;
  localparam logic [3:0]  OFS_STATUS  = 4'h4;
  localparam logic [3:0]  OFS_MADDR   = 4'h8;
  localparam logic [3:0]  OFS_MDATA   = 4'hc;
  // ctrl fields and reset value
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_HOLD_BIT = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h1;
  // status fields
  localparam int          ST_PROG_BIT  = 0;
  localparam int          ST_FULL_BIT  = 1;
  localparam int          ST_EMPTY_BIT = 2;
  localparam int          ST_MODE_LSB  = 4;
  localparam int          ST_ADDR_LSB  = 8;
  localparam int          ST_PHASE_LSB = 20;
  // fifo
  localparam int          FIFO_DEPTH  = 4;
  localparam int          ENTRY_W     = 1 + ADDR_W + BYTE_W;
  typedef enum logic [1:0] {
    OTPP_IDLE  = 2'b00,
    OTPP_HOLD  = 2'b01,
    OTPP_ARMED = 2'b10,
    OTPP_PROG  = 2'b11
  } otpp_state_t;
endpackage : otpp_pkg

// ### src/otpp_port.sv
// otpp_port: program/verify port of a 2048 x 16 one-time programmable store,
// with its commit fifo and a wishbone register slave.
// assumes all programmer pins are asynchronous to clk_i and the programmer
// keeps its own sequencing; the pad resolves the byte lane from the enable.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.

module otpp_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad
      $error("otpp_fifo depth must be a power of two, at least 2");
    end
  endgenerate
  logic [WIDTH-1:0] buf_r [DEPTH];
  logic [PW-1:0]    wp_r;
  logic [PW-1:0]    rp_r;
  logic [PW:0]      cnt_r;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;
  // honest flags straight from the count
  assign in_ready_o  = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = buf_r[rp_r];
  always_ff @(posedge clk_i) begin
    if (push) buf_r[wp_r] <= in_data_i;
  end
  // pointers and count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end
endmodule : otpp_fifo

// Behaviour
// - store holds 2048 words of 16 bits
// - address moves only on address clock pulses, or to zero in clear mode
// - four address clock pulses per address step
// - byte lane: programmer writes, device drives verify
// - enter programming after timed reset, then conditions
// - decode clear, write, verify, inhibit mode codes
// - verify drives stored data, four pulses per address
module otpp_port (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        prog_reset_n_i,
  input  wire logic        prog_cond_i,
  input  wire logic        addr_clk_i,
  input  wire logic [3:0]  mode_select_pins_i,
  input  wire logic [7:0]  byte_lane_pins_i,
  output logic [7:0]       byte_lane_pins_o,
  output logic             byte_lane_pins_oe_o
);
  localparam int AW = otpp_pkg::ADDR_W;
  localparam int BW = otpp_pkg::BYTE_W;
  localparam int EW = otpp_pkg::ENTRY_W;

  otpp_pkg::otpp_state_t state_r;
  otpp_pkg::otpp_state_t state_nxt;
  logic [otpp_pkg::WORD_W-1:0] store_r [otpp_pkg::WORDS];
  logic [14:0]   s1_r;
  logic [14:0]   s2_r;
  logic          clk_d_r;
  logic [AW-1:0] addr_r;
  logic [1:0]    phase_r;
  logic [9:0]    hold_cnt_r;
  logic          hold_ok_r;
  logic          was_write_r;
  logic          cap_pend_r;
  logic [EW-1:0] cap_data_r;
  logic [15:0]   rd_word_r;
  logic [15:0]   sw_word_r;
  logic [BW-1:0] byte_o_r;
  logic          oe_r;
  logic [1:0]    ctrl_r;
  logic [AW-1:0] sw_addr_r;
  logic [31:0]   dat_o_r;
  logic          ack_r;

  // pins pass two flops before any logic looks at them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {prog_cond_i, prog_reset_n_i, addr_clk_i, mode_select_pins_i, byte_lane_pins_i};
      s2_r <= s1_r;
    end
  end

  // synchronised pin views and mode decode
  wire [7:0] lane_s   = s2_r[7:0];
  wire [3:0] mode_s   = s2_r[11:8];
  wire       aclk_s   = s2_r[12];
  wire       prst_n_s = s2_r[13];
  wire       cond_s   = s2_r[14];
  wire       in_prog  = (state_r == otpp_pkg::OTPP_PROG);
  wire       m_clear  = in_prog && (mode_s == otpp_pkg::MODE_CLEAR);
  wire       m_write  = in_prog && (mode_s == otpp_pkg::MODE_WRITE);
  wire       m_verify = in_prog && (mode_s == otpp_pkg::MODE_VERIFY);
  wire       m_inh    = in_prog && ((mode_s & otpp_pkg::INH_MASK) == otpp_pkg::INH_CODE);
  wire       pulse    = in_prog && aclk_s && !clk_d_r && !m_clear;
  wire       last_ph  = (phase_r == 2'(otpp_pkg::PULSES_STEP - 1));

  // entry sequencing: timed reset hold, release, then programming conditions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      otpp_pkg::OTPP_IDLE:  if (ctrl_r[otpp_pkg::CTRL_EN_BIT] && !prst_n_s)
                              state_nxt = otpp_pkg::OTPP_HOLD;
      otpp_pkg::OTPP_HOLD:  if (prst_n_s)
                              state_nxt = hold_ok_r ? otpp_pkg::OTPP_ARMED
                                                    : otpp_pkg::OTPP_IDLE;
      otpp_pkg::OTPP_ARMED: if (!prst_n_s) state_nxt = otpp_pkg::OTPP_HOLD;
                            else if (cond_s) state_nxt = otpp_pkg::OTPP_PROG;
      otpp_pkg::OTPP_PROG:  if (!prst_n_s) state_nxt = otpp_pkg::OTPP_HOLD;
                            else if (!cond_s) state_nxt = otpp_pkg::OTPP_IDLE;
    endcase
    if (!ctrl_r[otpp_pkg::CTRL_EN_BIT]) state_nxt = otpp_pkg::OTPP_IDLE;
  end

  // state and reset-hold timer; a short hold never arms the port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= otpp_pkg::OTPP_IDLE;
      hold_cnt_r <= '0;
      hold_ok_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r != otpp_pkg::OTPP_HOLD) begin
        hold_cnt_r <= '0;
        hold_ok_r  <= 1'b0;
      end else if (hold_cnt_r == 10'(otpp_pkg::RST_HOLD_CY - 1)) begin
        hold_ok_r <= 1'b1;
      end else begin
        hold_cnt_r <= hold_cnt_r + 10'h001;
      end
    end
  end

  // address counter: clear mode zeroes it, every fourth pulse steps it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_d_r <= 1'b0;
      addr_r  <= '0;
      phase_r <= 2'h0;
    end else begin
      clk_d_r <= aclk_s;
      if (m_clear) begin
        addr_r  <= '0;
        phase_r <= 2'h0;
      end else if (pulse) begin
        phase_r <= phase_r + 2'h1;
        if (last_ph) addr_r <= addr_r + 1'b1;
      end
    end
  end

  // each entry into write mode with no capture pending takes one byte; phase picks the half, so
  // retries need no pulses and the half only moves on with the programmer
  wire          fifo_rdy;
  wire          fifo_vld;
  wire [EW-1:0] fifo_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      was_write_r <= 1'b0;
      cap_pend_r  <= 1'b0;
      cap_data_r  <= '0;
    end else begin
      was_write_r <= m_write;
      if (m_write && !was_write_r && !cap_pend_r) begin
        cap_pend_r <= 1'b1;
        cap_data_r <= {phase_r[1], addr_r, lane_s};
      end else if (fifo_rdy) begin
        cap_pend_r <= 1'b0;                                                      // stalls on full
      end
    end
  end

  otpp_fifo #(
    .WIDTH (EW),
    .DEPTH (otpp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (cap_pend_r),
    .in_ready_o  (fifo_rdy),
    .in_data_i   (cap_data_r),
    .out_valid_o (fifo_vld),
    .out_ready_i (!ctrl_r[otpp_pkg::CTRL_HOLD_BIT]),
    .out_data_o  (fifo_q)
  );

  // commit side; software hold stalls it so it can read back undisturbed
  wire          commit  = fifo_vld && !ctrl_r[otpp_pkg::CTRL_HOLD_BIT];
  wire          c_half  = fifo_q[EW-1];
  wire [AW-1:0] c_addr  = fifo_q[EW-2:BW];
  wire [BW-1:0] c_byte  = fifo_q[BW-1:0];
  always_ff @(posedge clk_i) begin
    if (commit) begin
      if (c_half) store_r[c_addr][15:8] <= c_byte;
      else store_r[c_addr][7:0] <= c_byte;
    end
    rd_word_r <= store_r[addr_r];
    sw_word_r <= store_r[sw_addr_r];
  end

  // byte lane drive: only in verify; inhibit and the rest release it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_o_r <= '0;
      oe_r     <= 1'b0;
    end else begin
      oe_r     <= m_verify;
      byte_o_r <= phase_r[1] ? rd_word_r[15:8] : rd_word_r[7:0];
    end
  end
  assign byte_lane_pins_o    = byte_o_r;
  assign byte_lane_pins_oe_o = oe_r;

  // wishbone slave: ack one cycle after the strobe, unmapped reads zero;
  // writes land on the edge that shows ack, while the master still holds them
  wire        wb_req   = wb_cyc_i && wb_stb_i && !ack_r;
  wire        wb_wr    = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  wire        sel_ctrl = (wb_adr_i == otpp_pkg::OFS_CTRL);
  wire        sel_stat = (wb_adr_i == otpp_pkg::OFS_STATUS);
  wire        sel_madr = (wb_adr_i == otpp_pkg::OFS_MADDR);
  wire        sel_mdat = (wb_adr_i == otpp_pkg::OFS_MDATA);
  wire [31:0] status_w = (32'(in_prog) << otpp_pkg::ST_PROG_BIT)
                       | (32'(!fifo_rdy) << otpp_pkg::ST_FULL_BIT)
                       | (32'(!fifo_vld) << otpp_pkg::ST_EMPTY_BIT)
                       | (32'(mode_s) << otpp_pkg::ST_MODE_LSB)
                       | (32'(addr_r) << otpp_pkg::ST_ADDR_LSB)
                       | (32'(phase_r) << otpp_pkg::ST_PHASE_LSB);
  wire [31:0] rd_mux   = sel_ctrl ? 32'(ctrl_r)
                       : sel_stat ? status_w
                       : sel_madr ? 32'(sw_addr_r)
                       : sel_mdat ? 32'(sw_word_r) : 32'h0000_0000;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r     <= 1'b0;
      dat_o_r   <= '0;
      ctrl_r    <= otpp_pkg::CTRL_RST;
      sw_addr_r <= '0;
    end else begin
      ack_r   <= wb_req;
      dat_o_r <= rd_mux;
      if (wb_wr && sel_ctrl && wb_sel_i[0]) ctrl_r <= wb_dat_i[1:0];
      if (wb_wr && sel_madr) begin
        if (wb_sel_i[0]) sw_addr_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) sw_addr_r[AW-1:8] <= wb_dat_i[AW-1:8];
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_o_r;

  // checks
  sequence s_step_edge;
    pulse && last_ph && !m_clear;
  endsequence
  sequence s_verify_held;
    m_verify [*2];
  endsequence

  AST_ADDR_ONLY_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    (addr_r != $past(addr_r)) |-> ($past(pulse) || $past(m_clear)))
    else $error("address moved without a clock pulse");
  AST_STEP_ON_FOURTH: assert property (@(posedge clk_i) disable iff (rst_i)
    s_step_edge |=> (addr_r == $past(addr_r) + 1'b1) && (phase_r == 2'h0))
    else $error("fourth pulse did not step the address");
  AST_NO_EARLY_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    (pulse && !last_ph) |=> $stable(addr_r))
    else $error("address stepped before the fourth pulse");
  AST_VERIFY_DRIVES: assert property (@(posedge clk_i) disable iff (rst_i)
    s_verify_held |-> oe_r)
    else $error("verify mode did not drive the byte lane");
  AST_INHIBIT_FLOAT: assert property (@(posedge clk_i) disable iff (rst_i)
    m_inh |=> !oe_r)
    else $error("byte lane driven in inhibit");
  AST_CAPTURE_ONLY_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(cap_pend_r) |-> $past(m_write))
    else $error("capture outside write mode");
  AST_ENTRY_TIMED: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_prog && !$past(in_prog)) |-> ($past(state_r) == otpp_pkg::OTPP_ARMED))
    else $error("programming entered without timed reset");
  AST_CLEAR_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    m_clear |=> (addr_r == '0) && (phase_r == 2'h0))
    else $error("clear mode did not zero the address");
  AST_LOW_BYTE_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
    (!phase_r[1] && oe_r) |=> (byte_o_r == $past(rd_word_r[7:0])))
    else $error("low byte not presented in first half");
endmodule : otpp_port

// ### bench/otpp_prog_model.sv
// otpp_prog_model: behavioural programmer driving the port's pins.
// assumes the bench resolves the byte lane, with a pull-down when nobody drives.
module otpp_prog_model #(
  parameter int WRITE_CY = 16
) (
  input  wire logic       clk_i,
  input  wire logic [7:0] lane_i,
  output logic            reset_n_o,
  output logic            cond_o,
  output logic            aclk_o,
  output logic [3:0]      mode_o,
  output logic [7:0]      data_o,
  output logic            drive_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // power-up pins: clock low, reset asserted, lane released
  initial begin
    reset_n_o = 1'b0;
    cond_o    = 1'b0;
    aclk_o    = 1'b0;
    mode_o    = otpp_pkg::INH_CODE;
    data_o    = 8'h00;
    drive_o   = 1'b0;
  end
  task automatic wait_cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_cy
  // 12 cycles per level so the device's two-flop sync has settled
  task automatic set_mode(input logic [3:0] m);
    @(posedge clk_i);
    mode_o <= m;
    wait_cy(12);
  endtask : set_mode
  task automatic enter(input int hold_cy);
    @(posedge clk_i);
    cond_o    <= 1'b0;
    reset_n_o <= 1'b0;
    wait_cy(hold_cy);
    reset_n_o <= 1'b1;
    set_mode(otpp_pkg::MODE_CLEAR);
    cond_o <= 1'b1;
    set_mode(otpp_pkg::INH_CODE);
  endtask : enter
  task automatic leave();
    set_mode(otpp_pkg::MODE_CLEAR);
    cond_o <= 1'b0;
    wait_cy(12);
  endtask : leave
  // address clock 80 ns high, 80 ns low; it stands low between bursts
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      aclk_o <= 1'b1;
      wait_cy(4);
      aclk_o <= 1'b0;
      wait_cy(3);
    end
    wait_cy(10);
  endtask : pulses
  // data is put on the lane before the mode changes, so the entry sees it
  task automatic write_once(input logic [7:0] d, input int cy);
    @(posedge clk_i);
    data_o  <= d;
    drive_o <= 1'b1;
    wait_cy(2);
    mode_o <= otpp_pkg::MODE_WRITE;
    wait_cy(cy);
    set_mode(otpp_pkg::INH_CODE);
    drive_o <= 1'b0;
  endtask : write_once
  task automatic drive_inh(input logic [7:0] d);
    @(posedge clk_i);
    data_o  <= d;
    drive_o <= 1'b1;
    set_mode(4'hf);
    drive_o <= 1'b0;
  endtask : drive_inh
  task automatic verify(output logic [7:0] b);
    set_mode(otpp_pkg::MODE_VERIFY);
    b = lane_i;
    set_mode(otpp_pkg::INH_CODE);
  endtask : verify
  // retry bound keeps a broken store from hanging the run
  task automatic prog_byte(input logic [7:0] d, output logic [7:0] b);
    int tries;
    tries = 0;
    do begin
      write_once(d, WRITE_CY);
      tries++;
      verify(b);
    end while (b !== d && tries < 25);
    write_once(d, tries * WRITE_CY);
  endtask : prog_byte
endmodule : otpp_prog_model

// ### bench/testbench.sv
// testbench: self-checking bench for the program/verify port.
// assumes the programmer model; a pull-down holds the idle lane low.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [3:0]  adr   = 4'h0;
  logic [31:0] dat   = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        rst_n;
  logic        cond;
  logic        aclk;
  logic [3:0]  mode;
  logic [7:0]  pdat;
  logic        pdrv;
  logic [7:0]  dbyte;
  logic        doe;
  logic [15:0] mem [0:3];
  logic [31:0] seed  = 32'hd7d1;
  logic [31:0] q;
  logic [7:0]  b;
  logic [7:0]  d;
  int          maddr = 0;
  int          mphase = 0;
  int          fail_count = 0;
  int          check_count = 0;
  // pad: device, else programmer, else pull-down
  wire  [7:0]  lane = doe ? dbyte : (pdrv ? pdat : 8'h00);
  always #10 clk_i = ~clk_i;
  otpp_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .prog_reset_n_i(rst_n), .prog_cond_i(cond), .addr_clk_i(aclk),
    .mode_select_pins_i(mode), .byte_lane_pins_i(lane), .byte_lane_pins_o(dbyte),
    .byte_lane_pins_oe_o(doe));
  otpp_prog_model #(.WRITE_CY(16)) i_prog (.clk_i(clk_i), .lane_i(lane),
    .reset_n_o(rst_n), .cond_o(cond), .aclk_o(aclk), .mode_o(mode), .data_o(pdat),
    .drive_o(pdrv));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // classic cycle: hold everything until ack is sampled, bounded wait
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v,
                    output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= v;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      print_verdict();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic st_chk(input logic prog);
    logic [31:0] s;
    logic [31:0] e;
    wb(1'b0, otpp_pkg::OFS_STATUS, 32'h0, s);
    // mode pins have stood long enough to be through the sync
    e = (32'(mphase) << 20) | (32'(maddr) << 8) | (32'(mode) << 4) | 32'(prog);
    chk(s & 32'h0037fff1, e);
  endtask : st_chk
  task automatic step(input int n);
    i_prog.pulses(n);
    mphase += n;
    maddr += mphase / 4;
    mphase = mphase % 4;
  endtask : step
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, otpp_pkg::OFS_CTRL, 32'h0, q);
    chk(q & 32'h3, 32'h1);
    wb(1'b0, 4'h2, 32'h0, q);
    chk(q, 32'h0);
    i_prog.pulses(4);
    st_chk(1'b0);
    i_prog.enter(100);
    st_chk(1'b0);
    i_prog.enter(520);
    st_chk(1'b1);
    // three words, low byte then high byte in each four-pulse cycle
    for (int a = 0; a < 3; a++) begin
      for (int h = 0; h < 2; h++) begin
        d = 8'(xs());
        i_prog.prog_byte(d, b);
        chk(32'(b), 32'(d));
        if (h == 0) mem[a][7:0] = d;
        else mem[a][15:8] = d;
        chk(32'(doe), 32'h0);
        step(2);
        st_chk(1'b1);
      end
    end
    // held commits fill the four-entry fifo; the fifth waits for room
    wb(1'b1, otpp_pkg::OFS_CTRL, 32'h3, q);
    for (int k = 0; k < 5; k++) begin
      d = 8'(xs());
      i_prog.write_once(d, 12);
    end
    mem[3][7:0] = d;
    wb(1'b0, otpp_pkg::OFS_STATUS, 32'h0, q);
    chk(32'(q[2:1]), 32'h1);
    wb(1'b1, otpp_pkg::OFS_CTRL, 32'h1, q);
    repeat (20) @(posedge clk_i);
    wb(1'b0, otpp_pkg::OFS_STATUS, 32'h0, q);
    chk(32'(q[2:1]), 32'h2);
    i_prog.drive_inh(~mem[0][7:0]);
    i_prog.set_mode(otpp_pkg::MODE_CLEAR);
    maddr = 0;
    mphase = 0;
    st_chk(1'b1);
    // read back with pulses arriving while verify stays selected
    i_prog.set_mode(otpp_pkg::MODE_VERIFY);
    for (int a = 0; a < 3; a++) begin
      for (int h = 0; h < 2; h++) begin
        chk(32'(doe), 32'h1);
        chk(32'(lane), 32'(h == 0 ? mem[a][7:0] : mem[a][15:8]));
        step(2);
      end
    end
    chk(32'(lane), 32'(mem[3][7:0]));
    i_prog.set_mode(otpp_pkg::INH_CODE);
    chk(32'(doe), 32'h0);
    wb(1'b1, otpp_pkg::OFS_MADDR, 32'hffff, q);
    wb(1'b0, otpp_pkg::OFS_MADDR, 32'h0, q);
    chk(q, 32'h7ff);
    wb(1'b1, otpp_pkg::OFS_MADDR, 32'h1, q);
    repeat (2) @(posedge clk_i);
    wb(1'b0, otpp_pkg::OFS_MDATA, 32'h0, q);
    chk(q & 32'hffff, 32'(mem[1]));
    i_prog.leave();
    wb(1'b0, otpp_pkg::OFS_STATUS, 32'h0, q);
    chk(q & 32'h1, 32'h0);
    print_verdict();
  end
endmodule : testbench
